// *** logic/mfps_pin_route.sv ***
`timescale 1ns/1ps
`include "mfps_defs.svh"
module mfps_pin_route
  import mfps_pkg::*;
#(
  parameter mfps_kind_t KIND = MFPS_KIND_INTERNAL_CLOCK_OUTPUT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstN,
  // configuration
  input wire mfps_sel_t selector,
  input wire logic staticLevel,
  mfps_src_if.use_src src,
  // pin side
  input wire logic pinInSync,
  output logic pinOut,
  output logic pinOe,
  output logic pinInEnable,
  output logic routedIn
);
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic inEn_reg, inEn_next;
  logic routed_reg, routed_next;

  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b1;
    inEn_next = 1'b0;
    routed_next = 1'b0;
    unique case (selector)
      `MFPS_SEL_INPUT: begin
        oe_next = 1'b0;
        inEn_next = 1'b1;
        routed_next = pinInSync;
      end
      `MFPS_SEL_STATIC: out_next = staticLevel;
      `MFPS_SEL_BITBANG: out_next = src.bitbangLevel;
      `MFPS_SEL_PDMCLK: out_next = src.pdmClk;
      `MFPS_SEL_06: begin
        out_next = (KIND == MFPS_KIND_EIGHT) ? src.irqLines[0] : src.internal_clock_output;
      end
      `MFPS_SEL_07: out_next = src.irqLines[1];
      `MFPS_SEL_08: out_next = src.irqLines[2];
      `MFPS_SEL_09: begin
        // no interrupt line on this code for pin eight
        out_next = (KIND == MFPS_KIND_EIGHT) ? 1'b0 : src.irqLines[3];
        oe_next = (KIND != MFPS_KIND_EIGHT);
      end
      `MFPS_SEL_0A: begin
        out_next = (KIND == MFPS_KIND_EIGHT) ? src.irqLines[3] : src.irqLines[4];
      end
      `MFPS_SEL_SA_WCLK: out_next = src.serAWordClk;
      `MFPS_SEL_SA_BCLK: out_next = src.serABitClk;
      `MFPS_SEL_SA_DATA: out_next = src.serAData;
      `MFPS_SEL_SA_WCLK2: out_next = src.serAWordClk;
      `MFPS_SEL_SB_BCLK: out_next = src.serBBitClk;
      `MFPS_SEL_SB_DATA: out_next = src.serBData;
      `MFPS_SEL_SC_WCLK: out_next = src.serCWordClk;
      `MFPS_SEL_SC_BCLK: out_next = src.serCBitClk;
      `MFPS_SEL_SC_DATA: out_next = src.serCData;
      default: begin
        // off and reserved codes both power the buffers down
        oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      inEn_reg <= 1'b0;
      routed_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      inEn_reg <= inEn_next;
      routed_reg <= routed_next;
    end
  end

  assign pinOut = out_reg;
  assign pinOe = oe_reg;
  assign pinInEnable = inEn_reg;
  assign routedIn = routed_reg;
endmodule : mfps_pin_route

// *** logic/mfps_top.sv ***
// Summary of operation
// - selector zero disables the pin, input and output buffers powered down.
// - selector one makes the pin an input routed to the input multiplexer.
// - selector three drives the pin from its own level bit.
// - selector four drives the pin from the shared bit-bang level.
// - selector five drives the pin with the PDM clock.
// - pins nine and ten, selector six outputs the internal clock output.
// - pins nine and ten, selectors seven to ten output interrupt lines one to four.
// - pin eight, selectors 6,7,8 give interrupts 0,1,2; selector 10 gives interrupt 3.
// - codes 12-13,16-18,21,27-29 output the three serial interfaces' clocks and data.
// - pin register: selector bits 4-0, level bit 6, reset zero.
// - input mode register: 2-bit modes at 5-4, 3-2, 1-0 for pins 3,2,1.
// - mode zero powers the input pin down, one routes it; two, three reserved.
`timescale 1ns/1ps
`include "mfps_defs.svh"
module mfps_top
  import mfps_pkg::*;
#(
  parameter int NUM_IN = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // internal signal sources
  input wire logic bitbangLevel,
  input wire logic pdmClk,
  input wire logic internal_clock_output,
  input wire logic [4:0] irqLines,
  input wire logic serAWordClk,
  input wire logic serABitClk,
  input wire logic serAData,
  input wire logic serBBitClk,
  input wire logic serBData,
  input wire logic serCWordClk,
  input wire logic serCBitClk,
  input wire logic serCData,
  // multipurpose pins eight, nine, ten
  input wire logic [2:0] mpPinIn,
  output logic [2:0] mpPinOut,
  output logic [2:0] mpPinOe,
  output logic [2:0] mpPinInEnable,
  output logic [2:0] mpRoutedIn,
  // general-purpose input pins
  input wire logic [NUM_IN-1:0] inPin,
  output logic [NUM_IN-1:0] inPinEnable,
  output logic [NUM_IN-1:0] inRouted
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rstMeta_reg, rstN_reg;
  logic rstMeta_next, rstN_next;
  // release on a clock edge so no flop sees reset end mid-cycle
  always_comb begin
    rstMeta_next = 1'b1;
    rstN_next = rstMeta_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstN_reg <= 1'b0;
    end else begin
      rstMeta_reg <= rstMeta_next;
      rstN_reg <= rstN_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  logic [2:0] mpMeta_reg, mpSync_reg;
  logic [2:0] mpMeta_next, mpSync_next;
  logic [NUM_IN-1:0] inMeta_reg, inSync_reg;
  logic [NUM_IN-1:0] inMeta_next, inSync_next;
  // logic reads only the second stage; the first may still be settling
  always_comb begin
    mpMeta_next = mpPinIn;
    mpSync_next = mpMeta_reg;
    inMeta_next = inPin;
    inSync_next = inMeta_reg;
  end

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      mpMeta_reg <= 3'h0;
      mpSync_reg <= 3'h0;
      inMeta_reg <= '0;
      inSync_reg <= '0;
    end else begin
      mpMeta_reg <= mpMeta_next;
      mpSync_reg <= mpSync_next;
      inMeta_reg <= inMeta_next;
      inSync_reg <= inSync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // reserved bits are writable storage, read back as written
  logic [7:0] pinCfg_reg [3];
  logic [7:0] pinCfg_next [3];
  logic [7:0] inMode_reg, inMode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] pinAddr [3];
  assign pinAddr[0] = `MFPS_ADDR_PIN8;
  assign pinAddr[1] = `MFPS_ADDR_PIN9;
  assign pinAddr[2] = `MFPS_ADDR_PIN10;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinCfg_next[i] = pinCfg_reg[i];
      if (regWrite && regAddr == pinAddr[i]) begin
        pinCfg_next[i] = regWdata;
      end
    end
    inMode_next = inMode_reg;
    if (regWrite && regAddr == `MFPS_ADDR_INMODE) begin
      inMode_next = regWdata;
    end
    // a read in the write cycle returns the old value
    rdata_next = rdata_reg;
    if (regRead) begin
      unique case (regAddr)
        `MFPS_ADDR_PIN8: rdata_next = pinCfg_reg[0];
        `MFPS_ADDR_PIN9: rdata_next = pinCfg_reg[1];
        `MFPS_ADDR_PIN10: rdata_next = pinCfg_reg[2];
        `MFPS_ADDR_INMODE: rdata_next = inMode_reg;
        default: rdata_next = `MFPS_READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      for (int i = 0; i < 3; i++) begin
        pinCfg_reg[i] <= `MFPS_REG_RESET;
      end
      inMode_reg <= `MFPS_REG_RESET;
      rdata_reg <= `MFPS_READ_IDLE;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pinCfg_reg[i] <= pinCfg_next[i];
      end
      inMode_reg <= inMode_next;
      rdata_reg <= rdata_next;
    end
  end
  assign regRdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // multipurpose pin routing
  // sources share mclk, so they reach the routers without synchronisers
  mfps_src_if srcBus ();
  assign srcBus.bitbangLevel = bitbangLevel;
  assign srcBus.pdmClk = pdmClk;
  assign srcBus.internal_clock_output = internal_clock_output;
  assign srcBus.irqLines = irqLines;
  assign srcBus.serAWordClk = serAWordClk;
  assign srcBus.serABitClk = serABitClk;
  assign srcBus.serAData = serAData;
  assign srcBus.serBBitClk = serBBitClk;
  assign srcBus.serBData = serBData;
  assign srcBus.serCWordClk = serCWordClk;
  assign srcBus.serCBitClk = serCBitClk;
  assign srcBus.serCData = serCData;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pin
      // pin eight has its own interrupt map, nine and ten carry the clock output
      mfps_pin_route #(
        .KIND((p == 0) ? MFPS_KIND_EIGHT : MFPS_KIND_INTERNAL_CLOCK_OUTPUT)
      ) u_route (
        .mclk(mclk),
        .rstN(rstN_reg),
        .selector(pinCfg_reg[p][`MFPS_SEL_MSB:`MFPS_SEL_LSB]),
        .staticLevel(pinCfg_reg[p][`MFPS_LEVEL_BIT]),
        .src(srcBus.use_src),
        .pinInSync(mpSync_reg[p]),
        .pinOut(mpPinOut[p]),
        .pinOe(mpPinOe[p]),
        .pinInEnable(mpPinInEnable[p]),
        .routedIn(mpRoutedIn[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // general-purpose input pins
  logic [NUM_IN-1:0] inEn_reg, inEn_next;
  logic [NUM_IN-1:0] inRouted_reg, inRouted_next;
  genvar k;
  generate
    for (k = 0; k < NUM_IN; k++) begin : g_in
      mfps_mode_t mode;
      assign mode = inMode_reg[k*`MFPS_MODE_W +: `MFPS_MODE_W];
      // reserved modes stay powered down rather than guessing a use
      always_comb begin
        inEn_next[k] = (mode == `MFPS_MODE_INPUT);
        inRouted_next[k] = (mode == `MFPS_MODE_INPUT) ? inSync_reg[k] : 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      inEn_reg <= '0;
      inRouted_reg <= '0;
    end else begin
      inEn_reg <= inEn_next;
      inRouted_reg <= inRouted_next;
    end
  end
  assign inPinEnable = inEn_reg;
  assign inRouted = inRouted_reg;
endmodule : mfps_top

// *** shared/mfps_defs.svh ***
`ifndef MFPS_DEFS_SVH
`define MFPS_DEFS_SVH

// register offsets
`define MFPS_ADDR_PIN8 8'h44
`define MFPS_ADDR_PIN9 8'h45
`define MFPS_ADDR_PIN10 8'h46
`define MFPS_ADDR_INMODE 8'h4D

// field layout of a multipurpose pin register
`define MFPS_SEL_MSB 4
`define MFPS_SEL_LSB 0
`define MFPS_LEVEL_BIT 6

// field layout of the input-pin mode register
`define MFPS_MODE_W 2
`define MFPS_INMODE_USED 6

`define MFPS_REG_RESET 8'h00
`define MFPS_READ_IDLE 8'h00

// selector codes
`define MFPS_SEL_OFF 5'h00
`define MFPS_SEL_INPUT 5'h01
`define MFPS_SEL_STATIC 5'h03
`define MFPS_SEL_BITBANG 5'h04
`define MFPS_SEL_PDMCLK 5'h05
`define MFPS_SEL_06 5'h06
`define MFPS_SEL_07 5'h07
`define MFPS_SEL_08 5'h08
`define MFPS_SEL_09 5'h09
`define MFPS_SEL_0A 5'h0A
`define MFPS_SEL_SA_WCLK 5'h0C
`define MFPS_SEL_SA_BCLK 5'h0D
`define MFPS_SEL_SA_DATA 5'h10
`define MFPS_SEL_SA_WCLK2 5'h11
`define MFPS_SEL_SB_BCLK 5'h12
`define MFPS_SEL_SB_DATA 5'h15
`define MFPS_SEL_SC_WCLK 5'h1B
`define MFPS_SEL_SC_BCLK 5'h1C
`define MFPS_SEL_SC_DATA 5'h1D

// input-pin mode codes
`define MFPS_MODE_OFF 2'h0
`define MFPS_MODE_INPUT 2'h1

`endif

// *** shared/mfps_pkg.sv ***
package mfps_pkg;
  typedef logic [4:0] mfps_sel_t;
  typedef logic [1:0] mfps_mode_t;
  // routing variant of a multipurpose pin
  typedef enum logic [1:0] {
    MFPS_KIND_EIGHT = 2'h1,
    MFPS_KIND_INTERNAL_CLOCK_OUTPUT = 2'h2
  } mfps_kind_t;
endpackage : mfps_pkg

// *** shared/mfps_src_if.sv ***
`timescale 1ns/1ps
interface mfps_src_if;
  logic bitbangLevel;
  logic pdmClk;
  logic internal_clock_output;
  logic [4:0] irqLines;
  logic serAWordClk;
  logic serABitClk;
  logic serAData;
  logic serBBitClk;
  logic serBData;
  logic serCWordClk;
  logic serCBitClk;
  logic serCData;
  modport drive (
    output bitbangLevel, pdmClk, internal_clock_output, irqLines, serAWordClk, serABitClk, serAData,
    output serBBitClk, serBData, serCWordClk, serCBitClk, serCData
  );
  modport use_src (
    input bitbangLevel, pdmClk, internal_clock_output, irqLines, serAWordClk, serABitClk, serAData,
    input serBBitClk, serBData, serCWordClk, serCBitClk, serCData
  );
endinterface : mfps_src_if

// *** verif/mfps_ext_model.sv ***
`timescale 1ns/1ps
module mfps_ext_model (
  // device side
  input wire logic [2:0] mpPinOut,
  input wire logic [2:0] mpPinOe,
  // outside levels
  input wire logic [2:0] extLevel,
  input wire logic [2:0] extIn,
  // wire levels
  output logic [2:0] mpPinIn,
  output logic [2:0] inPin
);
  // a driven pin shows the device's level, not the outside one
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mpPinIn[i] = mpPinOe[i] ? mpPinOut[i] : extLevel[i];
    end
  end
  assign inPin = extIn;
endmodule : mfps_ext_model

// *** verif/mfps_top_props.sv ***
`timescale 1ns/1ps
module mfps_top_props #(
  parameter int NUM_IN = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  // sources
  input wire logic bitbangLevel,
  input wire logic pdmClk,
  input wire logic internal_clock_output,
  input wire logic [4:0] irqLines,
  // pins
  input wire logic [2:0] mpPinOut,
  input wire logic [2:0] mpPinOe,
  input wire logic [2:0] mpPinInEnable,
  input wire logic [NUM_IN-1:0] inPinEnable
);
  logic [7:0] pinCopy_reg [3];
  logic [7:0] pinCopy_next [3];
  logic [7:0] modeCopy_reg;
  logic [7:0] modeCopy_next;
  logic [4:0] sel0;
  logic [4:0] sel1;
  logic [4:0] sel2;
  ////////////////////////////////////////////////////////////////////////
  // copy of the configuration, same edge as the device registers
  always_comb begin
    pinCopy_next = pinCopy_reg;
    modeCopy_next = modeCopy_reg;
    if (regWrite && regAddr >= 8'h44 && regAddr <= 8'h46) begin
      pinCopy_next[regAddr[1:0]] = regWdata;
    end
    if (regWrite && regAddr == 8'h4D) begin
      modeCopy_next = regWdata;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinCopy_reg <= '{default: 8'h00};
      modeCopy_reg <= 8'h00;
    end else begin
      pinCopy_reg <= pinCopy_next;
      modeCopy_reg <= modeCopy_next;
    end
  end
  assign sel0 = pinCopy_reg[0][4:0];
  assign sel1 = pinCopy_reg[1][4:0];
  assign sel2 = pinCopy_reg[2][4:0];
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_OFF: assert property (sel0 == 5'h00 |=> !mpPinOe[0] && !mpPinInEnable[0])
    else $error("disabled pin still has a buffer on");
  AST_INPUT: assert property (sel1 == 5'h01 |=> !mpPinOe[1] && mpPinInEnable[1])
    else $error("input selector did not make an input");
  AST_STATIC: assert property (sel1 == 5'h03 |=>
    mpPinOe[1] && mpPinOut[1] == $past(pinCopy_reg[1][6]))
    else $error("static drive wrong");
  AST_BITBANG: assert property (sel2 == 5'h04 |=>
    mpPinOe[2] && mpPinOut[2] == $past(bitbangLevel))
    else $error("bit-bang drive wrong");
  AST_PDM: assert property (sel1 == 5'h05 |=> mpPinOe[1] && mpPinOut[1] == $past(pdmClk))
    else $error("pdm clock drive wrong");
  AST_INTERNAL_CLOCK_OUTPUT: assert property (sel2 == 5'h06 |=>
    mpPinOe[2] && mpPinOut[2] == $past(internal_clock_output))
    else $error("clock output drive wrong");
  AST_IRQ: assert property (sel1 >= 5'h07 && sel1 <= 5'h0A |=>
    mpPinOe[1] && mpPinOut[1] == $past(irqLines[sel1 - 5'h06]))
    else $error("interrupt drive wrong on pin nine");
  AST_PIN8IRQ: assert property (sel0 inside {5'h06, 5'h07, 5'h08, 5'h0A} |=>
    mpPinOe[0] && mpPinOut[0] == $past(irqLines[(sel0 == 5'h0A) ? 5'h03 : sel0 - 5'h06]))
    else $error("interrupt drive wrong on pin eight");
  AST_PIN8NINE: assert property (sel0 == 5'h09 |=> !mpPinOe[0] && !mpPinInEnable[0])
    else $error("pin eight drives on a code it has no source for");
  AST_RESERVED: assert property (sel1 inside {5'h02, 5'h0B, 5'h0E, 5'h0F, 5'h13, 5'h14,
    [5'h16:5'h1A], 5'h1E, 5'h1F} |=> !mpPinOe[1] && !mpPinInEnable[1])
    else $error("reserved selector left a buffer on");
  AST_MODE: assert property (modeCopy_reg[5:4] == 2'h1 |=> inPinEnable[2])
    else $error("input pin three not enabled");
  AST_MODEOFF: assert property (modeCopy_reg[1:0] != 2'h1 |=> !inPinEnable[0])
    else $error("input pin one enabled in a non-input mode");
  cover property (sel1 == 5'h03);
  cover property (sel0 == 5'h0A);
  cover property (modeCopy_reg == 8'h15);
  cover property (sel2 == 5'h01);
endmodule : mfps_top_props

// *** verif/mfps_top_tb.sv ***
`timescale 1ns/1ps
module mfps_top_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [16:0] srcVec = 17'h00000;
  logic [2:0] extLevel = 3'h0;
  logic [2:0] extIn = 3'h0;
  logic [2:0] mpPinIn, mpPinOut, mpPinOe, mpPinInEnable, mpRoutedIn;
  logic [2:0] inPin, inPinEnable, inRouted;
  logic [7:0] addrs [5] = '{8'h44, 8'h45, 8'h46, 8'h4D, 8'h47};
  int bad_count = 0;
  int checks = 0;
  always #5 mclk = ~mclk;
  mfps_top dut (.mclk(mclk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .bitbangLevel(srcVec[0]),
    .pdmClk(srcVec[1]), .internal_clock_output(srcVec[2]), .irqLines(srcVec[7:3]), .serAWordClk(srcVec[8]),
    .serABitClk(srcVec[9]), .serAData(srcVec[10]), .serBBitClk(srcVec[11]),
    .serBData(srcVec[12]), .serCWordClk(srcVec[13]), .serCBitClk(srcVec[14]),
    .serCData(srcVec[15]), .mpPinIn(mpPinIn), .mpPinOut(mpPinOut), .mpPinOe(mpPinOe),
    .mpPinInEnable(mpPinInEnable), .mpRoutedIn(mpRoutedIn), .inPin(inPin),
    .inPinEnable(inPinEnable), .inRouted(inRouted));
  mfps_ext_model ext (.mpPinOut(mpPinOut), .mpPinOe(mpPinOe), .extLevel(extLevel),
    .extIn(extIn), .mpPinIn(mpPinIn), .inPin(inPin));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge mclk);
    regRead = 1'b0;
    @(negedge mclk);
    chk(regRdata, exp);
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // source index driving a pin for a code; -1 means no drive
  function automatic int srcIdx(input int pin, input int code);
    case (code)
      3: return 16;
      4: return 0;
      5: return 1;
      6: return (pin == 0) ? 3 : 2;
      7, 8: return code - 3;
      9: return (pin == 0) ? -1 : 6;
      10: return (pin == 0) ? 6 : 7;
      12, 17: return 8;
      13: return 9;
      16: return 10;
      18: return 11;
      21: return 12;
      27, 28, 29: return code - 14;
      default: return -1;
    endcase
  endfunction : srcIdx
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int idx;
    logic [2:0] expv;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 5; i++) begin
      rd(addrs[i], 8'h00);
      wr(addrs[i], 8'hFF);
      rd(addrs[i], (i < 4) ? 8'hFF : 8'h00);
      wr(addrs[i], 8'h00);
    end
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 32; c++) begin
        idx = srcIdx(p, c);
        for (int k = 0; k < 17; k++) begin
          srcVec = 17'h00001 << k;
          wr(8'h44 + p[7:0], {1'b0, srcVec[16], 1'b0, c[4:0]});
          repeat (2) @(negedge mclk);
          expv = {idx >= 0, (idx >= 0) ? srcVec[idx] : 1'b0, c == 1};
          chk({5'h00, mpPinOe[p], mpPinOut[p], mpPinInEnable[p]},
            {5'h00, expv});
        end
      end
    end
    $display("test selector sweep done");
    wr(8'h45, 8'h01);
    wr(8'h46, 8'h01);
    for (int v = 0; v < 2; v++) begin
      extLevel = {3{v[0]}};
      repeat (5) @(negedge mclk);
      chk({5'h00, mpRoutedIn}, {5'h00, v[0], v[0], 1'b0});
    end
    extIn = 3'h5;
    wr(8'h4D, 8'h15);
    repeat (5) @(negedge mclk);
    chk({2'h0, inPinEnable, inRouted}, 8'h3D);
    extIn = 3'h2;
    wr(8'h4D, 8'hE6);
    repeat (5) @(negedge mclk);
    chk({2'h0, inPinEnable, inRouted}, 8'h12);
    $display("test input routing done");
    wr(8'h46, 8'h43);
    repeat (2) @(negedge mclk);
    chk({4'h0, mpPinOe, mpPinOut[2]}, 8'h09);
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk({2'h0, mpPinOe, inPinEnable}, 8'h00);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd(8'h46, 8'h00);
    rd(8'h4D, 8'h00);
    $display("test reset done");
    summarize();
  end
  // sweep needs about 6500 cycles
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : mfps_top_tb
bind mfps_top mfps_top_props #(.NUM_IN(NUM_IN)) props (.mclk(mclk), .reset_n(reset_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .bitbangLevel(bitbangLevel),
  .pdmClk(pdmClk), .internal_clock_output(internal_clock_output), .irqLines(irqLines), .mpPinOut(mpPinOut),
  .mpPinOe(mpPinOe), .mpPinInEnable(mpPinInEnable), .inPinEnable(inPinEnable));
